// file: src/swt_ctrl.sv
/*
  Standby wake timer controller: standby control register, SLEEP
  dispatch, oscillator settling counter and event interrupt.
  Assumes sleep_req_i is a one-cycle pulse per SLEEP instruction and
  that all inputs are synchronous to core_clk_i.
*/
// The implementer's own choices: the placing of the registers and strobed register access.
`include "swt_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module swt_ctrl #(
  parameter int PCLK_DIV  = 1,
  parameter int WAIT_16K  = 16384,
  parameter int WAIT_32K  = 32768,
  parameter int WAIT_64K  = 65536,
  parameter int WAIT_128K = 131072,
  parameter int WAIT_256K = 262144,
  parameter int WAIT_512K = 524288
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        sleep_req_i,
  input  wire logic        ext_irq_i,
  input  wire logic        wake_irq_i,
  output logic             sleep_mode_o,
  output logic             standby_mode_o,
  output logic             settle_o,
  output logic             sleep_exc_o,
  output logic             irq_o
);

  // Refuse dividers the 8-bit prescaler cannot hold
  if (PCLK_DIV < 1 || PCLK_DIV > 256) begin : g_bad_div
    $error("PCLK_DIV must lie in 1..256");
  end
  // Long waits must fit the 20-bit counter
  if (WAIT_512K < 1 || WAIT_512K > 1048575) begin : g_bad_wait
    $error("WAIT_512K must lie in 1..1048575");
  end
  // A zero wait would wrap the counter and hold the core in settling for
  // a million ticks, so every shortened wait must be loadable as well
  if (WAIT_16K < 1 || WAIT_16K > 1048575
      || WAIT_32K < 1 || WAIT_32K > 1048575
      || WAIT_64K < 1 || WAIT_64K > 1048575
      || WAIT_128K < 1 || WAIT_128K > 1048575
      || WAIT_256K < 1 || WAIT_256K > 1048575) begin : g_bad_short
    $error("shortened waits must lie in 1..1048575");
  end

  swt_pkg::swt_ctrl_t  ctrl;
  swt_pkg::swt_state_t state;
  logic [15:0] status;
  logic [15:0] mask;
  logic [19:0] wait_cnt;
  logic [7:0]  div_cnt;
  logic        pclk_en;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_mask;
  logic [15:0] ev_set;
  logic        go_exc;
  logic        go_sleep;
  logic        go_stby;
  logic        wake_ext;
  logic        settle_last;

  // Selected wait length; reserved codes fall back to the 64-state wait
  function automatic logic [19:0] wait_len(input logic [4:0] code);
    logic [19:0] n;
    n = `SWT_CNT_64;
    case (code)
      `SWT_CODE_512:  n = `SWT_CNT_512;
      `SWT_CODE_1K:   n = `SWT_CNT_1K;
      `SWT_CODE_2K:   n = `SWT_CNT_2K;
      `SWT_CODE_4K:   n = `SWT_CNT_4K;
      `SWT_CODE_16K:  n = WAIT_16K[19:0];
      `SWT_CODE_32K:  n = WAIT_32K[19:0];
      `SWT_CODE_64K:  n = WAIT_64K[19:0];
      `SWT_CODE_128K: n = WAIT_128K[19:0];
      `SWT_CODE_256K: n = WAIT_256K[19:0];
      `SWT_CODE_512K: n = WAIT_512K[19:0];
      default:        n = `SWT_CNT_64;
    endcase
    return n;
  endfunction

  // Address decode of the one-cycle strobes
  assign wr_ctrl = wr_i && (addr_i == `SWT_CTRL_ADDR);
  assign wr_stat = wr_i && (addr_i == `SWT_STAT_ADDR);
  assign wr_mask = wr_i && (addr_i == `SWT_MASK_ADDR);

  // SLEEP dispatch decisions, only taken while running
  assign go_exc   = (state == swt_pkg::SWT_RUN) && sleep_req_i
                    && ctrl.sleep_exception_enable;
  assign go_sleep = (state == swt_pkg::SWT_RUN) && sleep_req_i
                    && !ctrl.sleep_exception_enable
                    && !ctrl.deep_standby_select;
  assign go_stby  = (state == swt_pkg::SWT_RUN) && sleep_req_i
                    && !ctrl.sleep_exception_enable
                    && ctrl.deep_standby_select;
  assign wake_ext = (state == swt_pkg::SWT_STANDBY) && ext_irq_i;
  assign settle_last = (state == swt_pkg::SWT_SETTLE) && pclk_en
                       && (wait_cnt == 20'h00001);

  // Peripheral clock enable; default divide by one ticks every cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= 8'h00;
    end else if (div_cnt == 8'(PCLK_DIV - 1)) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign pclk_en = (div_cnt == 8'(PCLK_DIV - 1));

  // Standby control register; reserved bits never store a one
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= swt_pkg::swt_ctrl_t'(`SWT_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl <= swt_pkg::swt_ctrl_t'(wdata_i & `SWT_CTRL_WMASK);
    end
  end

  // Power state machine
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= swt_pkg::SWT_RUN;
    end else begin
      case (state)
        swt_pkg::SWT_RUN: begin
          if (go_sleep) begin
            state <= swt_pkg::SWT_SLEEP;
          end else if (go_stby) begin
            state <= swt_pkg::SWT_STANDBY;
          end
        end
        swt_pkg::SWT_SLEEP: begin
          if (wake_irq_i || ext_irq_i) begin
            state <= swt_pkg::SWT_RUN;
          end
        end
        swt_pkg::SWT_STANDBY: begin
          if (ext_irq_i) begin
            state <= swt_pkg::SWT_SETTLE;
          end
        end
        swt_pkg::SWT_SETTLE: begin
          if (settle_last) begin
            state <= swt_pkg::SWT_RUN;
          end
        end
        default: state <= swt_pkg::SWT_RUN;
      endcase
    end
  end

  // Settling counter: loaded on wake, one step per peripheral tick
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 20'h00000;
    end else if (wake_ext) begin
      wait_cnt <= wait_len(ctrl.wait_select);
    end else if (state == swt_pkg::SWT_SETTLE && pclk_en) begin
      wait_cnt <= wait_cnt - 20'h00001;
    end
  end

  // Exception request pulse, one cycle per SLEEP taken as exception
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_exc_o <= 1'b0;
    end else begin
      sleep_exc_o <= go_exc;
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_comb begin
    ev_set = 16'h0000;
    ev_set[`SWT_EV_EXC]  = go_exc;
    ev_set[`SWT_EV_STBY] = go_stby;
    ev_set[`SWT_EV_WAKE] = settle_last;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status <= 16'h0000;
    end else if (wr_stat) begin
      status <= (status & ~wdata_i) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask <= 16'h0000;
    end else if (wr_mask) begin
      mask <= wdata_i & `SWT_EV_MASK;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (!rd_i) begin
      rdata_o <= 16'h0000;
    end else if (addr_i == `SWT_CTRL_ADDR) begin
      rdata_o <= 16'(ctrl) & `SWT_CTRL_WMASK;
    end else if (addr_i == `SWT_STAT_ADDR) begin
      rdata_o <= status;
    end else if (addr_i == `SWT_MASK_ADDR) begin
      rdata_o <= mask;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // Mode outputs decoded from the state register, interrupt from status and mask
  assign sleep_mode_o   = (state == swt_pkg::SWT_SLEEP);
  assign standby_mode_o = (state == swt_pkg::SWT_STANDBY);
  assign settle_o       = (state == swt_pkg::SWT_SETTLE);
  assign irq_o          = |(status & mask);

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctrl_read;
    rd_i && addr_i == `SWT_CTRL_ADDR;
  endsequence

  sequence s_wake;
    state == swt_pkg::SWT_STANDBY && ext_irq_i;
  endsequence

  sequence s_last_tick;
    state == swt_pkg::SWT_SETTLE && pclk_en && wait_cnt == 20'h00001;
  endsequence

  rsv_read_zero_a: assert property (s_ctrl_read |=> rdata_o[13] == 1'b0
      && rdata_o[6:0] == 7'h00)
    else $error("reserved control bits read nonzero");

  wait_load_a: assert property (s_wake |=> settle_o
      && wait_cnt == wait_len($past(ctrl.wait_select)))
    else $error("settle count not loaded from select");

  count_step_a: assert property ((settle_o && pclk_en && wait_cnt > 20'h00001)
      |=> settle_o && wait_cnt == $past(wait_cnt) - 20'h00001)
    else $error("settle count did not step on tick");

  count_hold_a: assert property ((settle_o && !pclk_en)
      |=> $stable(wait_cnt) && settle_o)
    else $error("settle count moved without tick");

  settle_done_a: assert property (s_last_tick |=> state == swt_pkg::SWT_RUN
      ##0 status[`SWT_EV_WAKE])
    else $error("no resume after count expiry");

  power_down_a: assert property ((!sleep_mode_o && !standby_mode_o && !settle_o
      && sleep_req_i && !ctrl.sleep_exception_enable)
      |=> (sleep_mode_o != $past(ctrl.deep_standby_select))
      && (standby_mode_o == $past(ctrl.deep_standby_select)))
    else $error("SLEEP target not chosen by standby select");

  exc_path_a: assert property ((state == swt_pkg::SWT_RUN && sleep_req_i
      && ctrl.sleep_exception_enable)
      |=> sleep_exc_o && state == swt_pkg::SWT_RUN ##1 !sleep_exc_o)
    else $error("exception SLEEP misbehaved");

  enable_hold_a: assert property ((ctrl.sleep_exception_enable
      && !(wr_ctrl && !wdata_i[7])) |=> ctrl.sleep_exception_enable)
    else $error("exception enable lost without write of zero");

  // Register store and read-back idle level
  sequence s_ctrl_write;
    wr_i && addr_i == `SWT_CTRL_ADDR;
  endsequence

  ctrl_store_a: assert property (s_ctrl_write
      |=> ctrl.wait_select == $past(wdata_i[12:8])
      && ctrl.sleep_exception_enable == $past(wdata_i[7]))
    else $error("control write not stored");

  rdata_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data stood beyond its cycle");

  // Power states are left only by the events that end them
  sequence s_stby_idle;
    state == swt_pkg::SWT_STANDBY && !ext_irq_i;
  endsequence

  sequence s_sleep_idle;
    state == swt_pkg::SWT_SLEEP && !ext_irq_i && !wake_irq_i;
  endsequence

  standby_hold_a: assert property (s_stby_idle |=> standby_mode_o)
    else $error("standby left without external interrupt");

  sleep_hold_a: assert property (s_sleep_idle |=> sleep_mode_o)
    else $error("sleep left without interrupt");

  settle_hold_a: assert property ((settle_o && !settle_last) |=> settle_o)
    else $error("settling ended before count expiry");

  // SLEEP outside normal running is ignored, and events stick at once
  busy_ignore_a: assert property ((!(state == swt_pkg::SWT_RUN) && sleep_req_i)
      |=> !sleep_exc_o)
    else $error("SLEEP acted on outside normal running");

  exc_event_a: assert property ((state == swt_pkg::SWT_RUN && sleep_req_i
      && ctrl.sleep_exception_enable) |=> status[`SWT_EV_EXC])
    else $error("exception event not recorded");

  stby_event_a: assert property ((state == swt_pkg::SWT_RUN && sleep_req_i
      && !ctrl.sleep_exception_enable && ctrl.deep_standby_select)
      |=> standby_mode_o && status[`SWT_EV_STBY])
    else $error("standby entry event not recorded");

  set_wins_a: assert property ((ev_set != 16'h0000)
      |=> (status & $past(ev_set)) == $past(ev_set))
    else $error("status event lost to a clear");

endmodule
`default_nettype wire

// file: pkg/swt_regs.svh
/*
  Register offsets, field positions, reset values and wait counts
  of the standby wake timer controller.
  Assumes a 4-bit word address and 16-bit data on the register port.
*/
`ifndef SWT_REGS_SVH
`define SWT_REGS_SVH

// Word addresses on the plain register port
`define SWT_CTRL_ADDR   4'h0
`define SWT_STAT_ADDR   4'h1
`define SWT_MASK_ADDR   4'h2

// Standby control reset value and writable bits (13 and 6..0 read 0)
`define SWT_CTRL_RST    16'h4F00
`define SWT_CTRL_WMASK  16'hDF80

// Event bit positions in status and mask
`define SWT_EV_EXC      0
`define SWT_EV_STBY     1
`define SWT_EV_WAKE     2
`define SWT_EV_MASK     16'h0007

// Wait select codes
`define SWT_CODE_64     5'h05
`define SWT_CODE_512    5'h06
`define SWT_CODE_1K     5'h07
`define SWT_CODE_2K     5'h08
`define SWT_CODE_4K     5'h09
`define SWT_CODE_16K    5'h0A
`define SWT_CODE_32K    5'h0B
`define SWT_CODE_64K    5'h0C
`define SWT_CODE_128K   5'h0D
`define SWT_CODE_256K   5'h0E
`define SWT_CODE_512K   5'h0F

// Wait lengths in peripheral clock states
`define SWT_CNT_64      20'h00040
`define SWT_CNT_512     20'h00200
`define SWT_CNT_1K      20'h00400
`define SWT_CNT_2K      20'h00800
`define SWT_CNT_4K      20'h01000
`define SWT_CNT_16K     20'h04000
`define SWT_CNT_32K     20'h08000
`define SWT_CNT_64K     20'h10000
`define SWT_CNT_128K    20'h20000
`define SWT_CNT_256K    20'h40000
`define SWT_CNT_512K    20'h80000

`endif

// file: pkg/swt_pkg.sv
/*
  Types of the standby wake timer controller.
  Assumes the offsets and counts come from swt_regs.svh.
*/
`default_nettype none
package swt_pkg;

  // Standby control register layout
  typedef struct packed {
    logic       deep_standby_select;
    logic       port_keep;
    logic       rsv13;
    logic [4:0] wait_select;
    logic       sleep_exception_enable;
    logic [6:0] rsv_low;
  } swt_ctrl_t;

  // Power state of the device
  typedef enum logic [1:0] {
    SWT_RUN,
    SWT_SLEEP,
    SWT_STANDBY,
    SWT_SETTLE
  } swt_state_t;

endpackage
`default_nettype wire

// file: tb/swt_ctrl_tb.sv
/*
  Self-checking bench of the standby wake timer controller.
  Assumes swt_regs.svh on the include path and swt_ctrl compiled first.
*/
`include "swt_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module swt_ctrl_tb;
  localparam int WS = 24; // Long waits shortened so the run stays brief
  localparam int PD = 2;  // Peripheral tick every second cycle, so holds are seen

  logic        core_clk_i  = 1'b0;
  logic        rst_i       = 1'b1;
  logic [3:0]  addr_i      = 4'h0;
  logic [15:0] wdata_i     = 16'h0000;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  logic        sleep_req_i = 1'b0;
  logic        ext_irq_i   = 1'b0;
  logic        wake_irq_i  = 1'b0;
  logic [15:0] rdata_o;
  logic        sleep_mode_o;
  logic        standby_mode_o;
  logic        settle_o;
  logic        sleep_exc_o;
  logic        irq_o;
  int          failures    = 0;
  int          compares    = 0;
  int          m_stat      = 0;
  logic [15:0] d;

  swt_ctrl #(.PCLK_DIV(PD), .WAIT_16K(WS), .WAIT_32K(WS + 8), .WAIT_64K(WS + 16),
    .WAIT_128K(WS + 24), .WAIT_256K(WS + 32), .WAIT_512K(WS + 40)) swt_ctrl_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_req_i(sleep_req_i),
    .ext_irq_i(ext_irq_i), .wake_irq_i(wake_irq_i), .sleep_mode_o(sleep_mode_o),
    .standby_mode_o(standby_mode_o), .settle_o(settle_o), .sleep_exc_o(sleep_exc_o),
    .irq_o(irq_o));

  // Model wait length of a select code
  function automatic int wait_of(input int code);
    case (code)
      5: return 64;
      6: return 512;
      7: return 1024;
      8: return 2048;
      9: return 4096;
      default: return WS + 8 * (code - 10);
    endcase
  endfunction

  // Compare a data word
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  // Compare a single flag
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask

  // Register read; data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk16(rdata_o, e);
  endtask

  task automatic flags(input logic sl, input logic sb, input logic st, input logic ex);
    chk1(sleep_mode_o, sl);
    chk1(standby_mode_o, sb);
    chk1(settle_o, st);
    chk1(sleep_exc_o, ex);
  endtask

  // Interrupt level follows the status and mask registers; look a cycle on
  task automatic irq_chk(input int mask);
    @(posedge core_clk_i);
    #1;
    chk1(irq_o, (m_stat & mask) != 0);
  endtask

  task automatic sleep_cmd();
    @(posedge core_clk_i);
    sleep_req_i <= 1'b1;
    @(posedge core_clk_i);
    sleep_req_i <= 1'b0;
    #1;
  endtask

  // Enter standby, wake by external interrupt, count settle cycles
  task automatic standby(input int code);
    int n;
    int w;
    n = 0;
    w = wait_of(code);
    wr(`SWT_CTRL_ADDR, 16'h8000 | 16'(code << 8));
    sleep_cmd();
    m_stat |= 2;
    flags(1'b0, 1'b1, 1'b0, 1'b0);
    // Other interrupts and a further SLEEP leave standby untouched
    @(posedge core_clk_i);
    wake_irq_i  <= 1'b1;
    sleep_req_i <= 1'b1;
    @(posedge core_clk_i);
    wake_irq_i  <= 1'b0;
    sleep_req_i <= 1'b0;
    #1;
    flags(1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge core_clk_i);
    ext_irq_i <= 1'b1;
    @(posedge core_clk_i);
    ext_irq_i <= 1'b0;
    #1;
    while (settle_o === 1'b1 && n < 9000) begin
      n++;
      @(posedge core_clk_i);
      #1;
    end
    // The first peripheral tick may come 1 to PD cycles after the load
    chk1(n > PD * (w - 1) && n <= PD * w, 1'b1);
    m_stat |= 4;
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    irq_chk(7);
  endtask

  task automatic finish_test();
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Watchdog well beyond the longest expected run
  initial begin
    #(60000 * 8);
    failures++;
    finish_test();
  end

  initial begin
    void'($urandom(92681));
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rchk(`SWT_CTRL_ADDR, 16'h4F00);
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    wr(`SWT_CTRL_ADDR, 16'h5F80);
    rchk(`SWT_CTRL_ADDR, 16'h5F80);
    rchk(4'hF, 16'h0000);
    // Random register traffic; control writes keep reserved bits at zero
    repeat (8) begin
      d = 16'($urandom);
      wr(`SWT_MASK_ADDR, d);
      rchk(`SWT_MASK_ADDR, d & 16'h0007);
      d = d & 16'hDF80;
      if (d[7]) begin
        d[15] = 1'b0;
      end
      wr(`SWT_CTRL_ADDR, d);
      rchk(`SWT_CTRL_ADDR, d & 16'hDF80);
    end
    wr(`SWT_MASK_ADDR, 16'h0007);
    // Sleep entry and wake by another interrupt
    wr(`SWT_CTRL_ADDR, 16'h0F00);
    sleep_cmd();
    flags(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge core_clk_i);
    wake_irq_i <= 1'b1;
    @(posedge core_clk_i);
    wake_irq_i <= 1'b0;
    #1;
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    // Sleep is left on the external interrupt as well
    sleep_cmd();
    flags(1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge core_clk_i);
    ext_irq_i <= 1'b1;
    @(posedge core_clk_i);
    ext_irq_i <= 1'b0;
    #1;
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    // Exception instead of power-down; enable stays set
    wr(`SWT_CTRL_ADDR, 16'h0F80);
    sleep_cmd();
    m_stat |= 1;
    flags(1'b0, 1'b0, 1'b0, 1'b1);
    irq_chk(7);
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    rchk(`SWT_CTRL_ADDR, 16'h0F80);
    rchk(`SWT_STAT_ADDR, 16'(m_stat));
    wr(`SWT_CTRL_ADDR, 16'h0F00);
    rchk(`SWT_CTRL_ADDR, 16'h0F00);
    // Masked status keeps the interrupt low, clear by writing ones
    wr(`SWT_MASK_ADDR, 16'h0000);
    irq_chk(0);
    wr(`SWT_MASK_ADDR, 16'h0007);
    irq_chk(7);
    wr(`SWT_STAT_ADDR, 16'h0007);
    m_stat = 0;
    irq_chk(7);
    rchk(`SWT_STAT_ADDR, 16'h0000);
    // Every defined wait code
    for (int c = 5; c <= 15; c++) begin
      standby(c);
      rchk(`SWT_STAT_ADDR, 16'(m_stat));
    end
    // Reset in mid-settle returns every register and output to idle
    wr(`SWT_CTRL_ADDR, 16'h8500);
    sleep_cmd();
    @(posedge core_clk_i);
    ext_irq_i <= 1'b1;
    @(posedge core_clk_i);
    ext_irq_i <= 1'b0;
    #1;
    chk1(settle_o, 1'b1);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    m_stat = 0;
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    chk1(irq_o, 1'b0);
    rchk(`SWT_CTRL_ADDR, 16'h4F00);
    rchk(`SWT_STAT_ADDR, 16'h0000);
    rchk(`SWT_MASK_ADDR, 16'h0000);
    finish_test();
  end
endmodule

`default_nettype wire
